// ---- common/ptsc_pkg.sv ----
// Package: register map, widths and reset values of the port T/S pin control block
package ptsc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int T_PINS = 8;
    localparam int S_PINS = 4;
    localparam int ROUTE_BITS = 5;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [3:0] OFF_T_PULL_ENABLE = 4'h4;
    localparam logic [3:0] OFF_T_PULL_POLARITY = 4'h5;
    localparam logic [3:0] OFF_T_MODULE_ROUTING = 4'h7;
    localparam logic [3:0] OFF_S_DATA = 4'h8;
    localparam logic [3:0] OFF_S_PIN_INPUT = 4'h9;
    localparam logic [3:0] OFF_S_DIRECTION = 4'hA;
    localparam logic [3:0] OFF_S_DRIVE_STRENGTH = 4'hB;

    // Values after reset
    localparam logic [7:0] RST_T_PULL_ENABLE = 8'h00;
    localparam logic [7:0] RST_T_PULL_POLARITY = 8'h00;
    localparam logic [4:0] RST_T_ROUTE = 5'h00;
    localparam logic [3:0] RST_S_DATA = 4'h0;
    localparam logic [3:0] RST_S_DIRECTION = 4'h0;
    localparam logic [3:0] RST_S_DRIVE = 4'h0;

    // Serial pin positions on port S
    localparam int S_RX_PIN = 0;
    localparam int S_TX_PIN = 1;

    // Synchroniser depth for pin levels
    localparam int SYNC_STAGES = 2;

endpackage

// ---- tb/ptsc_pads.sv ----
// Partner model: port S pads between the block and the board
`timescale 1ns/1ps
module ptsc_pads (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] board_lvl,
    output logic [3:0] pad
);
    // ====
    // Undriven pads show the board level, driven ones the block's value
    assign pad = (pin_oe_n & board_lvl) | (~pin_oe_n & pin_out);
endmodule

// ---- tb/ptsc_props.sv ----
// Checker: port timing and masking of ptsc_top
`timescale 1ns/1ps
module ptsc_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] t_pin_is_output,
    input wire logic [7:0] t_pull_up_en,
    input wire logic [7:0] t_pull_down_en,
    input wire logic serial_comm_unit_tx_en,
    input wire logic serial_comm_unit_rx_en,
    input wire logic serial_comm_unit_txd,
    input wire logic [3:0] s_pin_out,
    input wire logic [3:0] s_pin_oe_n,
    input wire logic [3:0] s_pin_reduced_drive
);
    // ====
    // Properties
    logic [2:0] up_q;
    // Internal reset copy lags arst_n by three edges
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            up_q <= 3'h0;
        else
            up_q <= {up_q[1:0], 1'b1};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n || !up_q[2]);
    property p_pull_out;
        $stable(t_pin_is_output)[*4] |->
            ((t_pull_up_en | t_pull_down_en) & t_pin_is_output) == 8'h00;
    endproperty
    a_pull_out: assert property (p_pull_out) else $error("pull on output");
    property p_pull_both;
        (t_pull_up_en & t_pull_down_en) == 8'h00;
    endproperty
    a_pull_both: assert property (p_pull_both) else $error("pull both");
    property p_tx;
        serial_comm_unit_tx_en |=>
            !s_pin_oe_n[1] && s_pin_out[1] == $past(serial_comm_unit_txd);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin");
    property p_rx;
        serial_comm_unit_rx_en |=> s_pin_oe_n[0];
    endproperty
    a_rx: assert property (p_rx) else $error("rx pin driven");
    property p_dir;
        reg_write && reg_addr == 4'hA ##1 !(reg_write && reg_addr == 4'hA) |=>
            s_pin_oe_n[3:2] == ~$past(reg_wdata[3:2], 2);
    endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_drive;
        (s_pin_reduced_drive & s_pin_oe_n) == 4'h0;
    endproperty
    a_drive: assert property (p_drive) else $error("drive on input");
    property p_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_rsvd;
        reg_read && reg_addr[3] |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits");
endmodule

bind ptsc_top ptsc_props props (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .t_pin_is_output, .t_pull_up_en, .t_pull_down_en, .serial_comm_unit_tx_en,
    .serial_comm_unit_rx_en, .serial_comm_unit_txd, .s_pin_out, .s_pin_oe_n,
    .s_pin_reduced_drive
);

// ---- tb/ptsc_top_tb_top.sv ----
// Testbench: register and pin scenarios for ptsc_top
`timescale 1ns/1ps
module ptsc_top_tb_top;
    import ptsc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] t_out = 8'hF0;
    logic [7:0] t_up;
    logic [7:0] t_dn;
    logic [4:0] t_sel;
    logic [4:0] tmr = 5'h13;
    logic [4:0] pwm = 5'h0C;
    logic [4:0] t_rt;
    logic tx_en = 1'b0;
    logic rx_en = 1'b0;
    logic txd = 1'b0;
    logic rxd;
    logic [3:0] pad;
    logic [3:0] board = 4'h3;
    logic [3:0] s_out;
    logic [3:0] s_oe_n;
    logic [3:0] s_red;
    logic [3:0] zr [8] = '{4'h4, 4'h5, 4'h7, 4'hA, 4'hB, 4'h0, 4'h6, 4'hF};
    int fail_count = 0;
    int checks = 0;
    // ====
    // Design and pads
    ptsc_top dut (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .t_pin_is_output(t_out), .t_pull_up_en(t_up), .t_pull_down_en(t_dn),
        .t_route_select(t_sel), .timer_module_out(tmr), .pwm_module_out(pwm),
        .t_routed_out(t_rt), .serial_comm_unit_tx_en(tx_en),
        .serial_comm_unit_rx_en(rx_en), .serial_comm_unit_txd(txd),
        .serial_comm_unit_rxd(rxd), .s_pin_in(pad), .s_pin_out(s_out),
        .s_pin_oe_n(s_oe_n), .s_pin_reduced_drive(s_red)
    );
    ptsc_pads pads (.pin_out(s_out), .pin_oe_n(s_oe_n), .board_lvl(board), .pad(pad));
    initial
        forever #12.5 clk = ~clk;
    // ====
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ====
    // Scenarios
    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (zr[i]) rd(zr[i], 8'h00);
        rd(4'h8, 8'h03);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h03);
        wr(4'h7, 8'hFF);
        rd(4'h7, 8'h1F);
        wr(4'hB, 8'hFF);
        rd(4'hB, 8'h0F);
        wr(4'h8, 8'h0B);
        wr(4'hA, 8'hFC);
        repeat (2) @(posedge clk);
        rd(4'hA, 8'h0C);
        rd(4'h8, 8'h0B);
        rd(4'h9, 8'h0B);
        chk({4'h0, s_oe_n}, 8'h03);
        chk({4'h0, s_red}, 8'h0C);
        // Pins lag the new latch here, so latch and pin views differ in every bit
        wr(4'h8, 8'h04);
        rd(4'h8, 8'h07);
        wr(4'h8, 8'h0B);
        @(posedge clk);
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        board <= 4'h2;
        wr(4'hA, 8'h0F);
        repeat (3) @(posedge clk);
        rd(4'h9, 8'h08);
        chk({4'h0, s_oe_n}, 8'h01);
        chk({7'h00, rxd}, 8'h00);
        @(posedge clk);
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({4'h0, s_oe_n}, 8'h00);
        rd(4'h9, 8'h0B);
        wr(4'h4, 8'hFF);
        wr(4'h5, 8'hAA);
        wr(4'h7, 8'h0F);
        repeat (2) @(posedge clk);
        #1 chk(t_up, 8'h05);
        chk(t_dn, 8'h0A);
        chk({3'h0, t_sel}, 8'h0F);
        chk({3'h0, t_rt}, 8'h1C);
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize;
    end
endmodule

// ---- verilog/ptsc_sync.sv ----
// Two-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ps
module ptsc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- verilog/ptsc_top.sv ----
// Port T pull/routing control and port S data/direction/drive control
`timescale 1ns/1ps
module ptsc_top
    import ptsc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [ptsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ptsc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [ptsc_pkg::DATA_W-1:0] reg_rdata,
    // Port T pins: direction comes from the port T direction logic outside this block
    input wire logic [ptsc_pkg::T_PINS-1:0] t_pin_is_output,
    output logic [ptsc_pkg::T_PINS-1:0] t_pull_up_en,
    output logic [ptsc_pkg::T_PINS-1:0] t_pull_down_en,
    output logic [ptsc_pkg::ROUTE_BITS-1:0] t_route_select,
    // Timer / PWM channel outputs and the routed result for port T[4:0]
    input wire logic [ptsc_pkg::ROUTE_BITS-1:0] timer_module_out,
    input wire logic [ptsc_pkg::ROUTE_BITS-1:0] pwm_module_out,
    output logic [ptsc_pkg::ROUTE_BITS-1:0] t_routed_out,
    // Serial unit controls and data
    input wire logic serial_comm_unit_tx_en,
    input wire logic serial_comm_unit_rx_en,
    input wire logic serial_comm_unit_txd,
    output logic serial_comm_unit_rxd,
    // Port S pins (three-signal form)
    input wire logic [ptsc_pkg::S_PINS-1:0] s_pin_in,
    output logic [ptsc_pkg::S_PINS-1:0] s_pin_out,
    output logic [ptsc_pkg::S_PINS-1:0] s_pin_oe_n,
    output logic [ptsc_pkg::S_PINS-1:0] s_pin_reduced_drive
);
    import ptsc_pkg::*;

    // ==========================================================
    // Reset release
    // ==========================================================
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic wr_t_pe, wr_t_pp, wr_t_rt, wr_s_dat, wr_s_dir, wr_s_drv;

    assign wr_t_pe = reg_write && hit(reg_addr, OFF_T_PULL_ENABLE);
    assign wr_t_pp = reg_write && hit(reg_addr, OFF_T_PULL_POLARITY);
    assign wr_t_rt = reg_write && hit(reg_addr, OFF_T_MODULE_ROUTING);
    assign wr_s_dat = reg_write && hit(reg_addr, OFF_S_DATA);
    assign wr_s_dir = reg_write && hit(reg_addr, OFF_S_DIRECTION);
    assign wr_s_drv = reg_write && hit(reg_addr, OFF_S_DRIVE_STRENGTH);

    // ==========================================================
    // Port T registers
    // ==========================================================
    logic [T_PINS-1:0] t_pull_enable_q;
    logic [T_PINS-1:0] t_pull_polarity_q;
    logic [ROUTE_BITS-1:0] t_route_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_pull_enable_q <= RST_T_PULL_ENABLE;
        end
        else if (wr_t_pe)
        begin
            t_pull_enable_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_pull_polarity_q <= RST_T_PULL_POLARITY;
        end
        else if (wr_t_pp)
        begin
            t_pull_polarity_q <= reg_wdata;
        end
    end

    // Bit 4 is stored as written; hardware does not police the four-channel case
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_route_q <= RST_T_ROUTE;
        end
        else if (wr_t_rt)
        begin
            t_route_q <= reg_wdata[ROUTE_BITS-1:0];
        end
    end

    // Pull controls are registered so the pad sees clean levels
    logic [T_PINS-1:0] t_dir_sync;

    ptsc_sync #(
        .WIDTH(T_PINS)
    ) u_t_dir_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(t_pin_is_output),
        .sync_out(t_dir_sync)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_pull_up_en <= '0;
            t_pull_down_en <= '0;
        end
        else
        begin
            t_pull_up_en <= t_pull_enable_q & ~t_pull_polarity_q & ~t_dir_sync;
            t_pull_down_en <= t_pull_enable_q & t_pull_polarity_q & ~t_dir_sync;
        end
    end

    assign t_route_select = t_route_q;

    genvar gi;
    generate
        for (gi = 0; gi < ROUTE_BITS; gi++)
        begin : g_route
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    t_routed_out[gi] <= 1'b0;
                end
                else
                begin
                    t_routed_out[gi] <= t_route_q[gi] ? pwm_module_out[gi]
                                                      : timer_module_out[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Port S registers
    // ==========================================================
    logic [S_PINS-1:0] s_port_data_q;
    logic [S_PINS-1:0] s_direction_q;
    logic [S_PINS-1:0] s_drive_strength_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_port_data_q <= RST_S_DATA;
        end
        else if (wr_s_dat)
        begin
            s_port_data_q <= reg_wdata[S_PINS-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_direction_q <= RST_S_DIRECTION;
        end
        else if (wr_s_dir)
        begin
            s_direction_q <= reg_wdata[S_PINS-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_drive_strength_q <= RST_S_DRIVE;
        end
        else if (wr_s_drv)
        begin
            s_drive_strength_q <= reg_wdata[S_PINS-1:0];
        end
    end

    // ==========================================================
    // Port S effective direction and pad drive
    // ==========================================================
    logic [S_PINS-1:0] s_eff_dir;
    logic [S_PINS-1:0] s_out_val;

    // Serial override takes precedence only while its channel is on
    always_comb
    begin
        s_eff_dir = s_direction_q;
        s_out_val = s_port_data_q;
        if (serial_comm_unit_tx_en)
        begin
            s_eff_dir[S_TX_PIN] = 1'b1;
            s_out_val[S_TX_PIN] = serial_comm_unit_txd;
        end
        if (serial_comm_unit_rx_en)
        begin
            s_eff_dir[S_RX_PIN] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_pin_out <= '0;
            s_pin_oe_n <= '1;
            s_pin_reduced_drive <= '0;
        end
        else
        begin
            s_pin_out <= s_out_val;
            s_pin_oe_n <= ~s_eff_dir;
            s_pin_reduced_drive <= s_drive_strength_q & s_eff_dir;
        end
    end

    // ==========================================================
    // Pin level sampling
    // ==========================================================
    // Two flops plus the pad output register are why reads may lag a direction change by three cycles
    logic [S_PINS-1:0] s_pin_level;

    ptsc_sync #(
        .WIDTH(S_PINS)
    ) u_s_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(s_pin_in),
        .sync_out(s_pin_level)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_comm_unit_rxd <= 1'b1;
        end
        else
        begin
            serial_comm_unit_rxd <= s_pin_level[S_RX_PIN];
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    logic [DATA_W-1:0] rdata_d;
    logic [S_PINS-1:0] s_data_view;

    assign s_data_view = (s_port_data_q & s_direction_q)
                       | (s_pin_level & ~s_direction_q);

    always_comb
    begin
        rdata_d = '0;
        case (reg_addr)
            OFF_T_PULL_ENABLE: rdata_d = t_pull_enable_q;
            OFF_T_PULL_POLARITY: rdata_d = t_pull_polarity_q;
            OFF_T_MODULE_ROUTING: rdata_d = {3'h0, t_route_q};
            OFF_S_DATA: rdata_d = {4'h0, s_data_view};
            OFF_S_PIN_INPUT: rdata_d = {4'h0, s_pin_level};
            OFF_S_DIRECTION: rdata_d = {4'h0, s_direction_q};
            OFF_S_DRIVE_STRENGTH: rdata_d = {4'h0, s_drive_strength_q};
            default: rdata_d = '0;
        endcase
    end

    // Read data holds for exactly one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
        end
        else if (reg_read)
        begin
            reg_rdata <= rdata_d;
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

endmodule
